// [core/flash_command_sequencer.v]
// Flash command sequencer: register file, command write sequence and launch queue
`timescale 1ns/10ps
`include "flash_seq_map.vh"
module flash_command_sequencer
#(
	parameter ARRAY_WORDS  = 65536,
	parameter PROG_TICKS   = 30,
	parameter SERASE_TICKS = 4000,
	parameter MERASE_TICKS = 20000
)
(
	input  wire        CLK_I,
	input  wire        RESET_I,
	input  wire        OSC_I,
	input  wire [3:0]  REG_ADDR_I,
	input  wire [7:0]  REG_WDATA_I,
	input  wire        REG_WR_I,
	input  wire        REG_RD_I,
	output reg  [7:0]  REG_RDATA_O,
	input  wire        ARR_WR_I,
	input  wire [15:0] ARR_ADDR_I,
	input  wire [15:0] ARR_WDATA_I,
	input  wire        PROTECTED_I,
	input  wire        DFAULT_I,
	input  wire [15:0] DFAULT_ADDR_I,
	input  wire [5:0]  DFAULT_PAR_I,
	input  wire [15:0] SIG_I,
	output reg  [6:0]  OP_CMD_O,
	output reg  [15:0] OP_ADDR_O,
	output reg  [15:0] OP_DATA_O,
	output wire        OP_BUSY_O,
	output reg         IRQ_O
);

localparam [1:0] SEQ_IDLE = 2'h0;
localparam [1:0] SEQ_ADDR = 2'h1;
localparam [1:0] SEQ_CMD  = 2'h2;

reg  [5:0]  div_val_ff;
reg         pre8_ff;
reg         div_ld_ff;
reg         ien_be_ff;
reg         ien_cc_ff;
reg         bef_ff;
reg         ccf_ff;
reg         protection_violation_flag_ff;
reg         access_error_flag_ff;
reg         dfault_ff;
reg  [1:0]  seq_ff;
reg  [15:0] buf_addr_ff;
reg  [15:0] buf_data_ff;
reg  [6:0]  buf_cmd_ff;
reg         buf_valid_ff;
reg  [2:0]  lcnt_ff;
reg         start_ff;
reg         abort_ff;
reg         abt_pend_ff;
reg  [15:0] cap_addr_ff;
reg  [15:0] cap_data_ff;
reg  [7:0]  nxt_rdata;

wire        tick;
wire        eng_busy;
wire        eng_done;
wire [7:0]  wd = REG_WDATA_I;
wire [6:0]  wcmd = REG_WDATA_I[6:0];
wire        wr_div  = REG_WR_I && (REG_ADDR_I == `OFS_DIV);
wire        wr_ctl  = REG_WR_I && (REG_ADDR_I == `OFS_CTL);
wire        wr_stat = REG_WR_I && (REG_ADDR_I == `OFS_STAT);
wire        wr_cmd  = REG_WR_I && (REG_ADDR_I == `OFS_CMD);
wire        cmd_ok  = (wcmd == `CMD_VERIFY) || (wcmd == `CMD_COMPRESS) ||
                      (wcmd == `CMD_PROGRAM) || (wcmd == `CMD_SERASE) ||
                      (wcmd == `CMD_MERASE) || (wcmd == `CMD_ABORT);
wire        act_run = eng_busy || start_ff;
wire        cmp_run = act_run && (OP_CMD_O == `CMD_COMPRESS);
wire        rd_run  = act_run && (OP_CMD_O == `CMD_VERIFY || OP_CMD_O == `CMD_COMPRESS);
wire        bef_hold = cmp_run || abt_pend_ff;
wire        prot_cmd = (buf_cmd_ff == `CMD_PROGRAM) || (buf_cmd_ff == `CMD_SERASE);

assign OP_BUSY_O = eng_busy;

// ****************************************
// Timing clock and operation timer
// ****************************************
timing_divider u_div
(
	.clk_i  (CLK_I),
	.rst_i  (RESET_I),
	.osc_i  (OSC_I),
	.run_i  (div_ld_ff),
	.pre8_i (pre8_ff),
	.div_i  (div_val_ff),
	.tick_o (tick)
);

op_engine
#(
	.ARRAY_WORDS  (ARRAY_WORDS),
	.PROG_TICKS   (PROG_TICKS),
	.SERASE_TICKS (SERASE_TICKS),
	.MERASE_TICKS (MERASE_TICKS)
)
u_eng
(
	.clk_i   (CLK_I),
	.rst_i   (RESET_I),
	.start_i (start_ff),
	.cmd_i   (OP_CMD_O),
	.data_i  (OP_DATA_O),
	.tick_i  (tick),
	.abort_i (abort_ff),
	.fault_i (DFAULT_I),
	.busy_o  (eng_busy),
	.done_o  (eng_done)
);

// ****************************************
// Read decode
// ****************************************
always @*
begin
	nxt_rdata = 8'h00;
	if (REG_ADDR_I == `OFS_DIV)
		nxt_rdata = {div_ld_ff, pre8_ff, div_val_ff};
	else if (REG_ADDR_I == `OFS_CTL)
		nxt_rdata = {ien_be_ff, ien_cc_ff, 6'h00};
	else if (REG_ADDR_I == `OFS_STAT)
		nxt_rdata = {bef_ff, ccf_ff, protection_violation_flag_ff, access_error_flag_ff, dfault_ff, 3'h0};
	else if (REG_ADDR_I == `OFS_CMD)
		nxt_rdata = {1'b0, buf_cmd_ff};
	else if (REG_ADDR_I == `OFS_CAPTURED_ADDRESS_HI)
		nxt_rdata = cap_addr_ff[15:8];
	else if (REG_ADDR_I == `OFS_CAPTURED_ADDRESS_LO)
		nxt_rdata = cap_addr_ff[7:0];
	else if (REG_ADDR_I == `OFS_CAPTURED_DATA_HI)
		nxt_rdata = cap_data_ff[15:8];
	else if (REG_ADDR_I == `OFS_CAPTURED_DATA_LO)
		nxt_rdata = cap_data_ff[7:0];
	else
		nxt_rdata = 8'h00;
end

// ****************************************
// Register file and sequence control
// ****************************************
always @(posedge CLK_I or posedge RESET_I)
begin
	if (RESET_I)
	begin
		div_val_ff   <= 6'h00;
		pre8_ff      <= 1'b0;
		div_ld_ff    <= 1'b0;
		ien_be_ff    <= 1'b0;
		ien_cc_ff    <= 1'b0;
		bef_ff       <= 1'b1;
		ccf_ff       <= 1'b1;
		protection_violation_flag_ff     <= 1'b0;
		access_error_flag_ff    <= 1'b0;
		dfault_ff    <= 1'b0;
		seq_ff       <= SEQ_IDLE;
		buf_addr_ff  <= 16'h0000;
		buf_data_ff  <= 16'h0000;
		buf_cmd_ff   <= 7'h00;
		buf_valid_ff <= 1'b0;
		lcnt_ff      <= 3'h0;
		start_ff     <= 1'b0;
		abort_ff     <= 1'b0;
		abt_pend_ff  <= 1'b0;
		cap_addr_ff  <= 16'h0000;
		cap_data_ff  <= 16'h0000;
		OP_CMD_O     <= 7'h00;
		OP_ADDR_O    <= 16'h0000;
		OP_DATA_O    <= 16'h0000;
		REG_RDATA_O  <= 8'h00;
		IRQ_O        <= 1'b0;
	end
	else
	begin
		start_ff    <= 1'b0;
		abort_ff    <= 1'b0;
		REG_RDATA_O <= REG_RD_I ? nxt_rdata : 8'h00;
		IRQ_O       <= (bef_ff & ien_be_ff) | (ccf_ff & ien_cc_ff);
		if (lcnt_ff != 3'h0)
			lcnt_ff <= lcnt_ff - 3'h1;
		if (abt_pend_ff && !eng_busy && !abort_ff)
			abt_pend_ff <= 1'b0;

		if (wr_div)
		begin
			div_val_ff <= wd[5:0];
			pre8_ff    <= wd[`BIT_PRE8];
			div_ld_ff  <= 1'b1;
		end
		if (wr_ctl)
		begin
			ien_be_ff <= wd[`BIT_IEN_BE];
			ien_cc_ff <= wd[`BIT_IEN_CC];
		end
		// Clears come first so that a same-cycle hardware set wins
		if (wr_stat && wd[`BIT_PROTECTION_VIOLATION_FLAG])
			protection_violation_flag_ff <= 1'b0;
		if (wr_stat && wd[`BIT_ACCESS_ERROR_FLAG])
		begin
			access_error_flag_ff <= 1'b0;
			dfault_ff <= 1'b0;
		end

		// Buffer empty returns once the gap has run, the queue is free and no compress or abort is pending
		if (!bef_ff && lcnt_ff <= 3'h1 && !buf_valid_ff && !bef_hold)
			bef_ff <= 1'b1;
		if (!ccf_ff && !buf_valid_ff && !act_run && !abt_pend_ff)
			ccf_ff <= 1'b1;

		// Move the queued command into the timer when it is free
		if (buf_valid_ff && !eng_busy && !start_ff)
		begin
			start_ff     <= 1'b1;
			buf_valid_ff <= 1'b0;
			OP_CMD_O     <= buf_cmd_ff;
			OP_ADDR_O    <= 16'h0000;
			OP_DATA_O    <= 16'h0000;
			if (buf_cmd_ff == `CMD_PROGRAM || buf_cmd_ff == `CMD_COMPRESS)
			begin
				OP_ADDR_O <= buf_addr_ff;
				OP_DATA_O <= buf_data_ff;
			end
			else if (buf_cmd_ff == `CMD_SERASE)
				OP_ADDR_O <= buf_addr_ff & `SECTOR_MASK;
		end

		// Step one: array write
		if (ARR_WR_I)
		begin
			if (access_error_flag_ff || protection_violation_flag_ff || ARR_ADDR_I[0] || cmp_run)
			begin
				access_error_flag_ff <= 1'b1;
				seq_ff    <= SEQ_IDLE;
			end
			else
			begin
				buf_addr_ff <= ARR_ADDR_I;
				buf_data_ff <= ARR_WDATA_I;
				cap_addr_ff <= ARR_ADDR_I;
				cap_data_ff <= ARR_WDATA_I;
				seq_ff      <= SEQ_ADDR;
				if (!bef_ff)
				begin
					bef_ff       <= 1'b1;
					buf_valid_ff <= 1'b0;
				end
			end
		end

		// Step two: command write
		if (wr_cmd)
		begin
			if (seq_ff == SEQ_ADDR && cmd_ok && div_ld_ff)
			begin
				buf_cmd_ff <= wcmd;
				seq_ff     <= SEQ_CMD;
			end
			else
			begin
				access_error_flag_ff <= 1'b1;
				seq_ff    <= SEQ_IDLE;
			end
		end

		// Step three: launch or abandon
		if (wr_stat && !wd[`BIT_BEF] && seq_ff != SEQ_IDLE)
		begin
			access_error_flag_ff <= 1'b1;
			seq_ff    <= SEQ_IDLE;
		end
		else if (wr_stat && wd[`BIT_BEF] && seq_ff == SEQ_ADDR)
		begin
			access_error_flag_ff <= 1'b1;
			seq_ff    <= SEQ_IDLE;
		end
		else if (wr_stat && wd[`BIT_BEF] && seq_ff == SEQ_CMD)
		begin
			seq_ff <= SEQ_IDLE;
			if (PROTECTED_I && prot_cmd)
				protection_violation_flag_ff <= 1'b1;
			else
			begin
				bef_ff  <= 1'b0;
				ccf_ff  <= 1'b0;
				lcnt_ff <= `LAUNCH_GAP;
				if (buf_cmd_ff != `CMD_ABORT)
					buf_valid_ff <= 1'b1;
				else if (eng_busy && OP_CMD_O == `CMD_SERASE)
				begin
					// Abort bypasses the queue; the sector is left unerased
					abort_ff    <= 1'b1;
					abt_pend_ff <= 1'b1;
					access_error_flag_ff   <= 1'b1;
				end
			end
		end

		// Completion and double faults; a first fault overrides a signature, a later one does not
		if (eng_done && OP_CMD_O == `CMD_COMPRESS)
			cap_data_ff <= SIG_I;
		if (DFAULT_I)
		begin
			access_error_flag_ff <= 1'b1;
			dfault_ff <= 1'b1;
			if (!dfault_ff)
			begin
				cap_addr_ff <= DFAULT_ADDR_I;
				cap_data_ff <= {10'h000, DFAULT_PAR_I};
			end
		end
		if (DFAULT_I && rd_run)
			seq_ff <= SEQ_IDLE;
	end
end

endmodule // flash_command_sequencer

// [core/flash_seq_map.vh]
// Register map, field positions, command codes and timing counts of the command sequencer
`ifndef FLASH_SEQ_MAP_VH
`define FLASH_SEQ_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_DIV      4'h0
`define OFS_CTL      4'h1
`define OFS_STAT     4'h2
`define OFS_CMD      4'h3
`define OFS_CAPTURED_ADDRESS_HI 4'h4
`define OFS_CAPTURED_ADDRESS_LO 4'h5
`define OFS_CAPTURED_DATA_HI 4'h6
`define OFS_CAPTURED_DATA_LO 4'h7
`define OFS_TEST_A   4'h8
`define OFS_TEST_D   4'hb

// ****************************************
// Field positions
// ****************************************
`define BIT_BEF      7
`define BIT_CCF      6
`define BIT_PROTECTION_VIOLATION_FLAG    5
`define BIT_ACCESS_ERROR_FLAG   4
`define BIT_DFAULT   3
`define BIT_IEN_BE   7
`define BIT_IEN_CC   6
`define BIT_PRE8     6

// ****************************************
// Command codes and timing
// ****************************************
`define CMD_VERIFY   7'h05
`define CMD_COMPRESS 7'h06
`define CMD_PROGRAM  7'h20
`define CMD_SERASE   7'h40
`define CMD_MERASE   7'h41
`define CMD_ABORT    7'h47
`define LAUNCH_GAP   3'h4
`define VERIFY_EXTRA 18'h0000c
`define CMP_EXTRA    18'h00014
`define SECTOR_MASK  16'hfc00

`endif

// [core/timing_divider.v]
// Timing clock tick generator from the oscillator input
`timescale 1ns/10ps
module timing_divider
(
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       osc_i,
	input  wire       run_i,
	input  wire       pre8_i,
	input  wire [5:0] div_i,
	output reg        tick_o
);

reg       osc_m_ff;
reg       osc_s_ff;
reg       osc_d_ff;
reg [2:0] pre_ff;
reg [5:0] cnt_ff;
wire      osc_rise = osc_s_ff & ~osc_d_ff;

// ****************************************
// Divide oscillator edges by eight when pre8 is set, then by div plus one
// ****************************************
always @(posedge clk_i or posedge rst_i)
begin
	if (rst_i)
	begin
		osc_m_ff <= 1'b0;
		osc_s_ff <= 1'b0;
		osc_d_ff <= 1'b0;
		pre_ff   <= 3'h0;
		cnt_ff   <= 6'h00;
		tick_o   <= 1'b0;
	end
	else
	begin
		osc_m_ff <= osc_i;
		osc_s_ff <= osc_m_ff;
		osc_d_ff <= osc_s_ff;
		tick_o   <= 1'b0;
		if (run_i && osc_rise)
		begin
			if (pre8_i && pre_ff != 3'h7)
				pre_ff <= pre_ff + 3'h1;
			else
			begin
				pre_ff <= 3'h0;
				if (cnt_ff == div_i)
				begin
					cnt_ff <= 6'h00;
					tick_o <= 1'b1;
				end
				else
					cnt_ff <= cnt_ff + 6'h01;
			end
		end
	end
end

endmodule // timing_divider

// [core/op_engine.v]
// Operation timer: runs one launched command to its end
`timescale 1ns/10ps
`include "flash_seq_map.vh"
module op_engine
#(
	parameter ARRAY_WORDS  = 65536,
	parameter PROG_TICKS   = 30,
	parameter SERASE_TICKS = 4000,
	parameter MERASE_TICKS = 20000
)
(
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        start_i,
	input  wire [6:0]  cmd_i,
	input  wire [15:0] data_i,
	input  wire        tick_i,
	input  wire        abort_i,
	input  wire        fault_i,
	output reg         busy_o,
	output reg         done_o
);

localparam [17:0] VER_CYC = ARRAY_WORDS;
localparam [17:0] PRG_T   = PROG_TICKS;
localparam [17:0] SER_T   = SERASE_TICKS;
localparam [17:0] MER_T   = MERASE_TICKS;

reg  [17:0] cnt_ff;
reg         tmode_ff;
wire [16:0] cmp_n = (data_i == 16'h0000) ? 17'h10000 : {1'b0, data_i};

// ****************************************
// Bus-cycle timed reads, tick timed program and erase
// ****************************************
always @(posedge clk_i or posedge rst_i)
begin
	if (rst_i)
	begin
		cnt_ff   <= 18'h00000;
		tmode_ff <= 1'b0;
		busy_o   <= 1'b0;
		done_o   <= 1'b0;
	end
	else
	begin
		done_o <= 1'b0;
		if (start_i)
		begin
			busy_o   <= 1'b1;
			tmode_ff <= 1'b1;
			case (cmd_i)
			`CMD_VERIFY:
			begin
				cnt_ff   <= VER_CYC + `VERIFY_EXTRA;
				tmode_ff <= 1'b0;
			end
			`CMD_COMPRESS:
			begin
				cnt_ff   <= {cmp_n, 1'b0} + `CMP_EXTRA;
				tmode_ff <= 1'b0;
			end
			`CMD_PROGRAM: cnt_ff <= PRG_T;
			`CMD_SERASE:  cnt_ff <= SER_T;
			default:      cnt_ff <= MER_T;
			endcase
		end
		else if (busy_o)
		begin
			// A read-type pass stops dead on an uncorrectable word
			if (abort_i || (fault_i && !tmode_ff))
				busy_o <= 1'b0;
			else if (!tmode_ff || tick_i)
			begin
				if (cnt_ff <= 18'h00001)
				begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end
				else
					cnt_ff <= cnt_ff - 18'h00001;
			end
		end
	end
end

endmodule // op_engine

// [verif/array_side_model.sv]
// Model of the array, fault detector and oscillator that feed the sequencer
`timescale 1ns/10ps
module array_side_model
#(
	parameter SIG = 16'h5a3c
)
(
	input  wire        clk_i,
	input  wire        fault_req_i,
	input  wire [15:0] fault_addr_i,
	input  wire [5:0]  fault_par_i,
	output reg         osc_o,
	output reg         dfault_o,
	output reg  [15:0] dfault_addr_o,
	output reg  [5:0]  dfault_par_o,
	output wire [15:0] sig_o
);
	// ****************
	// Oscillator, unrelated in phase to the bus clock
	// ****************
	initial
	begin
		osc_o = 1'b0;
		dfault_o = 1'b0;
		dfault_addr_o = 16'h0000;
		dfault_par_o = 6'h00;
	end
	always #37 osc_o = ~osc_o;
	assign sig_o = SIG;
	// Fault lines toggle while not valid, so a stale capture cannot pass
	always @(posedge clk_i)
	begin
		dfault_o <= fault_req_i;
		dfault_addr_o <= fault_req_i ? fault_addr_i : ~dfault_addr_o;
		dfault_par_o <= fault_req_i ? fault_par_i : ~dfault_par_o;
	end
endmodule // array_side_model

// [verif/flash_command_sequencer_props.sv]
// Port assertions of the flash command sequencer
`timescale 1ns/10ps
`include "flash_seq_map.vh"
module flash_command_sequencer_props
(
	input wire        CLK_I,
	input wire        RESET_I,
	input wire [3:0]  REG_ADDR_I,
	input wire        REG_WR_I,
	input wire        REG_RD_I,
	input wire [7:0]  REG_RDATA_O,
	input wire [6:0]  OP_CMD_O,
	input wire [15:0] OP_ADDR_O,
	input wire [15:0] OP_DATA_O,
	input wire        OP_BUSY_O
);
	// ****************
	// Divider seen; a run before it means a refused command slipped through
	// ****************
	reg div_seen_ff;
	always @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
			div_seen_ff <= 1'b0;
		else if (REG_WR_I && REG_ADDR_I == `OFS_DIV)
			div_seen_ff <= 1'b1;
	end
	default clocking dc @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	AST_TEST_ZERO: assert property (
		REG_RD_I && REG_ADDR_I >= `OFS_TEST_A && REG_ADDR_I <= `OFS_TEST_D
		|=> REG_RDATA_O == 8'h00) else $error("test register read not zero");
	AST_NO_DIV_NO_RUN: assert property (!div_seen_ff |-> !OP_BUSY_O)
		else $error("operation ran before divider write");
	AST_SERASE_OPS: assert property (
		OP_BUSY_O && OP_CMD_O == `CMD_SERASE |-> OP_ADDR_O[9:0] == 10'h000
		&& OP_DATA_O == 16'h0000) else $error("sector erase operands wrong");
	AST_NO_OPERANDS: assert property (
		OP_BUSY_O && (OP_CMD_O == `CMD_VERIFY || OP_CMD_O == `CMD_MERASE)
		|-> OP_ADDR_O == 16'h0000 && OP_DATA_O == 16'h0000) else $error("operands not ignored");
	AST_ALIGNED: assert property (
		OP_BUSY_O && OP_CMD_O == `CMD_PROGRAM |-> !OP_ADDR_O[0]) else $error("odd program address");
	AST_VALID_CODE: assert property (
		OP_BUSY_O |-> OP_CMD_O inside {`CMD_VERIFY, `CMD_COMPRESS, `CMD_PROGRAM,
		`CMD_SERASE, `CMD_MERASE, `CMD_ABORT}) else $error("invalid command ran");
	AST_HOLD_CMD: assert property (
		OP_BUSY_O && $past(OP_BUSY_O) |-> $stable(OP_CMD_O) || OP_CMD_O == `CMD_ABORT)
		else $error("command changed during operation");
	AST_COMPRESS_BEF: assert property (
		OP_BUSY_O && OP_CMD_O == `CMD_COMPRESS && REG_RD_I && REG_ADDR_I == `OFS_STAT
		|=> !REG_RDATA_O[`BIT_BEF]) else $error("buffer empty set during compress");
endmodule // flash_command_sequencer_props
bind flash_command_sequencer flash_command_sequencer_props props (
	.CLK_I(CLK_I), .RESET_I(RESET_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I),
	.REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .OP_CMD_O(OP_CMD_O),
	.OP_ADDR_O(OP_ADDR_O), .OP_DATA_O(OP_DATA_O), .OP_BUSY_O(OP_BUSY_O)
);

// [verif/flash_command_sequencer_test.sv]
// Self-checking bench of the flash command sequencer
`timescale 1ns/10ps
`include "flash_seq_map.vh"
`define CHK(g, e) begin checks = checks + 1; if ((g) !== (e)) begin fails = fails + 1; \
	$display("BAD %0t %h %h", $time, (g), (e)); end end
module flash_command_sequencer_test;
	// ****************
	// Signals; rows are offset, reset value, write value, value after
	// ****************
	localparam [255:0] ROWS = {32'h08000000, 32'h09000000, 32'h0a000000, 32'h0b000000,
		32'h0c000000, 32'h0f000000, 32'h02c030c0, 32'h0100c0c0};
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg  [3:0]  addr = 4'h0;
	reg  [7:0]  wdata = 8'h00;
	reg         wen = 1'b0;
	reg         ren = 1'b0;
	reg         awr = 1'b0;
	reg  [15:0] aaddr = 16'h0000;
	reg  [15:0] adata = 16'h0000;
	reg         freq = 1'b0;
	reg  [15:0] fa = 16'h0000;
	reg  [5:0]  fp = 6'h00;
	reg  [7:0]  got = 8'h00;
	wire        osc, dfault, busy, irq;
	wire [15:0] daddr, sig, oaddr, odata;
	wire [5:0]  dpar;
	wire [6:0]  ocmd;
	wire [7:0]  rdata;
	integer     i, fails = 0, checks = 0;
	always #5 clk = ~clk;
	array_side_model model (.clk_i(clk), .fault_req_i(freq), .fault_addr_i(fa),
		.fault_par_i(fp), .osc_o(osc), .dfault_o(dfault), .dfault_addr_o(daddr),
		.dfault_par_o(dpar), .sig_o(sig));
	// Short counts keep the run brief; protection is not exercised here
	flash_command_sequencer #(.ARRAY_WORDS(16), .PROG_TICKS(2), .SERASE_TICKS(8),
		.MERASE_TICKS(6)) dut (.CLK_I(clk), .RESET_I(rst), .OSC_I(osc), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_WR_I(wen), .REG_RD_I(ren), .REG_RDATA_O(rdata),
		.ARR_WR_I(awr), .ARR_ADDR_I(aaddr), .ARR_WDATA_I(adata), .PROTECTED_I(1'b0),
		.DFAULT_I(dfault), .DFAULT_ADDR_I(daddr), .DFAULT_PAR_I(dpar), .SIG_I(sig),
		.OP_CMD_O(ocmd), .OP_ADDR_O(oaddr), .OP_DATA_O(odata), .OP_BUSY_O(busy),
		.IRQ_O(irq));
	// ****************
	// Bus tasks
	// ****************
	task wr(input [3:0] a, input [7:0] d);
	begin
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wen <= 1'b1;
		@(posedge clk);
		wen <= 1'b0;
	end
	endtask
	// A zero mask only reads, for polling
	task rd(input [3:0] a, input [7:0] m, input [7:0] e);
	begin
		@(posedge clk);
		addr <= a;
		ren <= 1'b1;
		@(posedge clk);
		ren <= 1'b0;
		#1;
		got = rdata;
		if (m !== 8'h00) `CHK(rdata & m, e)
	end
	endtask
	task aw(input [15:0] a, input [15:0] d);
	begin
		@(posedge clk);
		aaddr <= a;
		adata <= d;
		awr <= 1'b1;
		@(posedge clk);
		awr <= 1'b0;
	end
	endtask
	task seq(input [15:0] a, input [15:0] d, input [6:0] c, input [7:0] l);
	begin
		aw(a, d);
		wr(`OFS_CMD, {1'b0, c});
		wr(`OFS_STAT, l);
	end
	endtask
	task capchk(input [31:0] v);
	begin
		for (i = 0; i < 4; i = i + 1)
			rd(`OFS_CAPTURED_ADDRESS_HI + i[3:0], 8'hff, v[31 - 8 * i -: 8]);
	end
	endtask
	task wait_cc;
	integer n;
	begin
		got = 8'h00;
		for (n = 0; n < 200 && got[`BIT_CCF] !== 1'b1; n = n + 1)
			rd(`OFS_STAT, 8'h00, 8'h00);
		`CHK(got[`BIT_CCF], 1'b1)
	end
	endtask
	task wait_busy(input v);
	integer n;
	begin
		for (n = 0; n < 200 && busy !== v; n = n + 1)
		begin
			@(posedge clk);
			#1;
		end
		`CHK(busy, v)
	end
	endtask
	task end_sim;
	begin
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	initial
	begin
		#60000;
		fails = fails + 1;
		end_sim;
	end
	// ****************
	// Tests
	// ****************
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 8; i = i + 1)
		begin
			got = ROWS[255 - 32 * i -: 8];
			rd(got[3:0], 8'hff, ROWS[247 - 32 * i -: 8]);
			wr(ROWS[251 - 32 * i -: 4], ROWS[239 - 32 * i -: 8]);
			rd(ROWS[251 - 32 * i -: 4], 8'hff, ROWS[231 - 32 * i -: 8]);
		end
		`CHK(irq, 1'b1)
		wr(`OFS_CTL, 8'h40);
		seq(16'h0100, 16'h0001, `CMD_PROGRAM, 8'h80);
		rd(`OFS_STAT, 8'h10, 8'h10);
		wr(`OFS_STAT, 8'h10);
		wr(`OFS_DIV, 8'h00);
		rd(`OFS_DIV, 8'h80, 8'h80);
		for (i = 0; i < 2; i = i + 1)
		begin
			seq(16'h0100, 16'h0001, i ? `CMD_PROGRAM : 7'h7f, i ? 8'h00 : 8'h80);
			rd(`OFS_STAT, 8'h10, 8'h10);
			wr(`OFS_STAT, 8'h10);
		end
		seq(16'h1234, 16'hbeef, `CMD_PROGRAM, 8'h80);
		rd(`OFS_STAT, 8'hc0, 8'h00);
		`CHK(irq, 1'b0)
		repeat (2) @(posedge clk);
		rd(`OFS_STAT, 8'hc0, 8'h80);
		`CHK({ocmd, oaddr, odata}, {`CMD_PROGRAM, 16'h1234, 16'hbeef})
		capchk(32'h1234beef);
		wr(`OFS_CAPTURED_ADDRESS_HI, 8'h00);
		rd(`OFS_CAPTURED_ADDRESS_HI, 8'hff, 8'h12);
		wait_cc;
		seq(16'h5678, 16'h0000, `CMD_SERASE, 8'h80);
		repeat (4) @(posedge clk);
		rd(`OFS_STAT, 8'h80, 8'h80);
		seq(16'h0002, 16'h0011, `CMD_PROGRAM, 8'h80);
		repeat (4) @(posedge clk);
		rd(`OFS_STAT, 8'h80, 8'h00);
		aw(16'h0ab0, 16'h0022);
		rd(`OFS_STAT, 8'h80, 8'h80);
		wr(`OFS_CMD, {1'b0, `CMD_PROGRAM});
		wr(`OFS_STAT, 8'h80);
		`CHK({ocmd, oaddr}, {`CMD_SERASE, 16'h5400})
		wait_busy(1'b0);
		rd(`OFS_STAT, 8'h40, 8'h00);
		wait_busy(1'b1);
		`CHK({ocmd, oaddr, odata}, {`CMD_PROGRAM, 16'h0ab0, 16'h0022})
		wait_cc;
		// Fault report while idle
		@(posedge clk);
		freq <= 1'b1;
		fa <= 16'h4321;
		fp <= 6'h2a;
		@(posedge clk);
		freq <= 1'b0;
		rd(`OFS_STAT, 8'h18, 8'h18);
		capchk(32'h4321002a);
		wr(`OFS_STAT, 8'h10);
		seq(16'h0010, 16'h0002, `CMD_COMPRESS, 8'h80);
		repeat (4) @(posedge clk);
		rd(`OFS_STAT, 8'h80, 8'h00);
		`CHK(odata, 16'h0002)
		wait_cc;
		capchk({16'h0010, 16'h5a3c});
		for (i = 0; i < 3; i = i + 1)
		begin
			seq(16'h0200, 16'h0033, i == 0 ? `CMD_VERIFY : i == 1 ? `CMD_MERASE : `CMD_ABORT,
				8'h80);
			wait_cc;
		end
		end_sim;
	end
endmodule // flash_command_sequencer_test
